/* hdl/amch_pkg.sv */
// shared constants and types of the assembled move command handshake
package amch_pkg;

  // register port geometry
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 16;
  localparam int CMD_WORDS = 10;

  // register map: command words sit at their word number, status above them
  localparam logic [ADDR_W-1:0] ADDR_CMD_LAST = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_STATUS0  = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_ENC_UP   = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_ENC_LO   = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_SEG_CNT  = 5'h13;

  // command block word numbers
  localparam int W_CTRL   = 0;
  localparam int W_OPT    = 1;
  localparam int W_POS_UP = 2;
  localparam int W_POS_LO = 3;
  localparam int W_SPD_UP = 4;
  localparam int W_SPD_LO = 5;
  localparam int W_ACC    = 6;
  localparam int W_DEC    = 7;
  localparam int W_AUX    = 9;

  // command word 0 codes
  localparam logic [DATA_W-1:0] CODE_RUN        = 16'h2000;
  localparam logic [DATA_W-1:0] CODE_ENC_PRESET = 16'h4000;
  localparam logic [DATA_W-1:0] CODE_FIRST      = 16'h0800;
  localparam logic [DATA_W-1:0] CODE_POS_PRESET = 16'h0200;
  localparam logic [DATA_W-1:0] CODE_RESET_ERR  = 16'h0400;

  // command bit positions
  localparam int BIT_SEG_STROBE = 12;
  localparam int BIT_DWELL_SEL  = 9;
  localparam int BIT_REVERSE    = 4;

  // status word 0 bit positions
  localparam int ST_CMD_ERR  = 12;
  localparam int ST_SEG_WAIT = 9;
  localparam int ST_IN_ASSY  = 8;
  localparam int ST_MOVE_CMP = 7;

  // segment storage
  localparam int MAX_SEGS  = 16;
  localparam int SEG_IDX_W = 4;
  localparam int SEG_CNT_W = 5;
  localparam int POS_W     = 24;
  localparam int SPD_W     = 22;
  localparam int RATE_W    = 13;
  localparam int SEG_W     = POS_W + SPD_W + 3 * RATE_W;
  localparam int ENC_W     = 32;
  localparam logic [SEG_CNT_W-1:0] SEG_MAX_CNT = 5'h10;
  localparam logic [SEG_CNT_W-1:0] SEG_ONE     = 5'h01;

  // profile loading handshake states
  typedef enum logic [2:0] {
    AMCH_IDLE     = 3'b001,
    AMCH_WAIT_SEG = 3'b010,
    AMCH_WAIT_CLR = 3'b100
  } amch_load_t;

endpackage

/* hdl/amch_seg_store.sv */
// segment memory of the assembled profile with a registered read port
module amch_seg_store import amch_pkg::*; (
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 wr_en_i,
  input  wire logic [SEG_IDX_W-1:0] wr_idx_i,
  input  wire logic [SEG_W-1:0]     wr_data_i,
  input  wire logic [SEG_IDX_W-1:0] rd_idx_i,
  output logic      [SEG_W-1:0]     rd_data_o
);

  logic [SEG_W-1:0] mem [MAX_SEGS];

  // no reset on the array: entries past the stored count are never trusted
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  // read data lands one cycle after the index
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end

endmodule

/* hdl/amch_top.sv */
// command block decoder and segment loading handshake of the stepper indexer
//
// Implementation choices: strobed register access and the placing of the registers.

// Notes on behaviour
// - run code starts the stored profile
// - option bit 9 picks blended or dwell
// - option bit 4 gives blended direction inversion
// - dwell uses word 9 pause; blended ignores
// - unused command words are simply ignored
// - encoder preset loads counter from words 2,3
// - first block code enters loading mode
// - first block sets status bits 8 and 9
// - segment words 2,3 hold relative position
// - segment words 4,5 hold speed
// - words 6,7,9 hold accel, decel, jerk
// - bit 12 stores segment, clears bit 9
// - bit 12 low sets bit 9 again
// - at most sixteen segments are stored
// - same block format for blend and dwell
// - bit 9 segment ready, bit 8 loading
// - bit 7 move complete, cleared by commands
module amch_top import amch_pkg::*; (
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic [ADDR_W-1:0]    bus_addr_i,
  input  wire logic [DATA_W-1:0]    bus_wdata_i,
  input  wire logic                 bus_wr_i,
  input  wire logic                 bus_rd_i,
  output logic      [DATA_W-1:0]    bus_rdata_o,
  input  wire logic                 profile_done_i,
  input  wire logic                 enc_inc_i,
  input  wire logic                 enc_dec_i,
  input  wire logic [SEG_IDX_W-1:0] seg_rd_idx_i,
  output logic                      run_start_o,
  output logic                      run_dwell_o,
  output logic                      run_reverse_o,
  output logic      [DATA_W-1:0]    run_dwell_ms_o,
  output logic      [SEG_CNT_W-1:0] run_seg_count_o,
  output logic      [POS_W-1:0]     seg_pos_o,
  output logic      [SPD_W-1:0]     seg_speed_o,
  output logic      [RATE_W-1:0]    seg_accel_o,
  output logic      [RATE_W-1:0]    seg_decel_o,
  output logic      [RATE_W-1:0]    seg_jerk_o,
  output logic                      loading_o,
  output logic                      seg_wait_o,
  output logic                      move_cmp_o,
  output logic                      cmd_err_o,
  output logic      [ENC_W-1:0]     enc_pos_o
);

  logic [DATA_W-1:0]    cmd_word [CMD_WORDS];
  logic [DATA_W-1:0]    ctrl_prev;
  amch_load_t           load_state;
  amch_load_t           next_state;
  logic [SEG_CNT_W-1:0] seg_count;
  logic [SEG_W-1:0]     seg_rd_data;

  // command words are plain storage; the host may leave stale values in them
  for (genvar gi = 0; gi < CMD_WORDS; gi++) begin : g_cmd
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cmd_word[gi] <= '0;
      end else if (bus_wr_i && (bus_addr_i == ADDR_W'(gi))) begin
        cmd_word[gi] <= bus_wdata_i;
      end
    end
  end

  // command decode: a code acts once, on the cycle it first appears in word 0
  wire [DATA_W-1:0] ctrl        = cmd_word[W_CTRL];
  wire              run_edge    = (ctrl == CODE_RUN) && (ctrl_prev != CODE_RUN);
  wire              enc_edge    = (ctrl == CODE_ENC_PRESET)
                                  && (ctrl_prev != CODE_ENC_PRESET);
  wire              first_edge  = (ctrl == CODE_FIRST) && (ctrl_prev != CODE_FIRST);
  wire              pos_edge    = (ctrl == CODE_POS_PRESET) && (ctrl_prev != CODE_POS_PRESET);
  wire              rst_edge    = (ctrl == CODE_RESET_ERR) && (ctrl_prev != CODE_RESET_ERR);
  wire              dwell_sel   = cmd_word[W_OPT][BIT_DWELL_SEL];
  wire              rev_sel     = cmd_word[W_OPT][BIT_REVERSE];
  wire [DATA_W-1:0] aux_word    = cmd_word[W_AUX];
  wire [ENC_W-1:0]  preset_val  = {cmd_word[W_POS_UP], cmd_word[W_POS_LO]};

  // segment handshake terms; only bit 12 is looked at, so a missing bit 11 is tolerated
  wire seg_strobe  = ctrl[BIT_SEG_STROBE];
  wire seg_room    = seg_count < SEG_MAX_CNT;
  wire seg_take    = (load_state == AMCH_WAIT_SEG) && seg_strobe;
  wire seg_store   = seg_take && seg_room;
  wire seg_reject  = seg_take && !seg_room;
  wire seg_release = (load_state == AMCH_WAIT_CLR) && !seg_strobe;

  // segment fields, binary upper/lower join; word 8 and upper bits are never read
  wire [ENC_W-1:0]  pos_full  = {cmd_word[W_POS_UP], cmd_word[W_POS_LO]};
  wire [ENC_W-1:0]  spd_full  = {cmd_word[W_SPD_UP], cmd_word[W_SPD_LO]};
  wire [SEG_W-1:0]  seg_word  = {pos_full[POS_W-1:0],
                                 spd_full[SPD_W-1:0],
                                 cmd_word[W_ACC][RATE_W-1:0],
                                 cmd_word[W_DEC][RATE_W-1:0],
                                 cmd_word[W_AUX][RATE_W-1:0]};

  // moves and presets clear move complete; a finishing move in the same cycle wins
  wire cmp_clear = run_edge || enc_edge || pos_edge || rst_edge;

  // status word 0 as software reads it
  wire [DATA_W-1:0] status0 = (DATA_W'(cmd_err_o)  << ST_CMD_ERR)
                            | (DATA_W'(seg_wait_o) << ST_SEG_WAIT)
                            | (DATA_W'(loading_o)  << ST_IN_ASSY)
                            | (DATA_W'(move_cmp_o) << ST_MOVE_CMP);

  // read mux; unmapped addresses answer zero
  wire              addr_cmd = bus_addr_i <= ADDR_CMD_LAST;
  wire [DATA_W-1:0] cmd_rd   = addr_cmd ? cmd_word[bus_addr_i[SEG_IDX_W-1:0]] : '0;
  wire [DATA_W-1:0] rd_mux   = addr_cmd                       ? cmd_rd :
                               (bus_addr_i == ADDR_STATUS0)   ? status0 :
                               (bus_addr_i == ADDR_ENC_UP)    ? enc_pos_o[ENC_W-1:DATA_W] :
                               (bus_addr_i == ADDR_ENC_LO)    ? enc_pos_o[DATA_W-1:0] :
                               (bus_addr_i == ADDR_SEG_CNT)   ? DATA_W'(seg_count) :
                                                                '0;

  // loading handshake next state; a new first block restarts the load
  always_comb begin
    next_state = load_state;
    unique case (load_state)
      AMCH_IDLE: begin
        if (first_edge) begin
          next_state = AMCH_WAIT_SEG;
        end
      end
      AMCH_WAIT_SEG: begin
        if (first_edge) begin
          next_state = AMCH_WAIT_SEG;
        end else if (run_edge) begin
          next_state = AMCH_IDLE;
        end else if (seg_take) begin
          next_state = AMCH_WAIT_CLR;
        end
      end
      AMCH_WAIT_CLR: begin
        if (first_edge) begin
          next_state = AMCH_WAIT_SEG;
        end else if (run_edge) begin
          next_state = AMCH_IDLE;
        end else if (seg_release) begin
          next_state = AMCH_WAIT_SEG;
        end
      end
      default: begin
        next_state = AMCH_IDLE;
      end
    endcase
  end

  // state and its status bits move together so software never sees them disagree
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_state <= AMCH_IDLE;
      loading_o  <= 1'b0;
      seg_wait_o <= 1'b0;
      ctrl_prev  <= '0;
    end else begin
      load_state <= next_state;
      loading_o  <= next_state != AMCH_IDLE;
      seg_wait_o <= next_state == AMCH_WAIT_SEG;
      ctrl_prev  <= ctrl;
    end
  end

  // segment counter; a rejected block still walks the handshake so the host is not stuck
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg_count <= '0;
    end else if (first_edge) begin
      seg_count <= '0;
    end else if (seg_store) begin
      seg_count <= seg_count + SEG_ONE;
    end
  end

  // sticky flags: the set term is or-ed outside the clear term so it beats a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_err_o  <= 1'b0;
      move_cmp_o <= 1'b0;
    end else begin
      cmd_err_o  <= seg_reject || (cmd_err_o && !rst_edge);
      move_cmp_o <= profile_done_i || (move_cmp_o && !cmp_clear);
    end
  end

  // run command: options are caught once, so later edits of word 1 or 9 do nothing
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_start_o     <= 1'b0;
      run_dwell_o     <= 1'b0;
      run_reverse_o   <= 1'b0;
      run_dwell_ms_o  <= '0;
      run_seg_count_o <= '0;
    end else begin
      run_start_o <= run_edge;
      if (run_edge) begin
        run_dwell_o     <= dwell_sel;
        run_reverse_o   <= !dwell_sel && rev_sel;
        run_dwell_ms_o  <= dwell_sel ? aux_word : '0;
        run_seg_count_o <= seg_count;
      end
    end
  end

  // encoder position counter; the preset outranks counting in the same cycle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enc_pos_o <= '0;
    end else if (enc_edge) begin
      enc_pos_o <= preset_val;
    end else if (enc_inc_i && !enc_dec_i) begin
      enc_pos_o <= enc_pos_o + ENC_W'(1);
    end else if (enc_dec_i && !enc_inc_i) begin
      enc_pos_o <= enc_pos_o - ENC_W'(1);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_rdata_o <= '0;
    end else begin
      bus_rdata_o <= bus_rd_i ? rd_mux : '0;
    end
  end

  amch_seg_store u_store (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_en_i    (seg_store),
    .wr_idx_i   (seg_count[SEG_IDX_W-1:0]),
    .wr_data_i  (seg_word),
    .rd_idx_i   (seg_rd_idx_i),
    .rd_data_o  (seg_rd_data)
  );

  // unpack the stored segment for the motion engine
  assign seg_pos_o   = seg_rd_data[SEG_W-1 -: POS_W];
  assign seg_speed_o = seg_rd_data[3*RATE_W +: SPD_W];
  assign seg_accel_o = seg_rd_data[2*RATE_W +: RATE_W];
  assign seg_decel_o = seg_rd_data[RATE_W +: RATE_W];
  assign seg_jerk_o  = seg_rd_data[RATE_W-1:0];

  // checks on the handshake and command effects
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_seg_taken;
    (load_state == AMCH_WAIT_SEG) && seg_strobe && seg_room;
  endsequence

  sequence s_seg_released;
    (load_state == AMCH_WAIT_CLR) && !seg_strobe && !run_edge && !first_edge;
  endsequence

  a_first_block: assert property (first_edge |=> loading_o && seg_wait_o && (seg_count == '0))
    else $error("first block did not raise loading and segment request");

  a_seg_store: assert property (s_seg_taken |=> !seg_wait_o && loading_o
                                && (seg_count == $past(seg_count) + SEG_ONE))
    else $error("segment not stored or request bit not cleared");

  // the rearm step is checked alone: the host holds the strobe across its status poll
  a_seg_cycle: assert property (s_seg_released |=> seg_wait_o && loading_o)
    else $error("request bit not raised again after strobe release");

  a_seg_cap: assert property (seg_count <= SEG_MAX_CNT)
    else $error("more than sixteen segments counted");

  a_seg_reject: assert property (seg_reject |=> cmd_err_o && !seg_wait_o
                                 && (seg_count == SEG_MAX_CNT))
    else $error("overflow segment not rejected with command error");

  a_run_select: assert property (run_edge |=> run_start_o && !loading_o
                                 && (run_dwell_o == $past(dwell_sel)))
    else $error("run did not start with the selected variant");

  a_run_reverse: assert property (run_edge |=> run_reverse_o == (!$past(dwell_sel)
                                  && $past(rev_sel)))
    else $error("blend direction inversion taken wrongly");

  a_dwell_time: assert property (run_edge |=> run_dwell_ms_o
                                 == ($past(dwell_sel) ? $past(aux_word) : 16'h0000))
    else $error("dwell time not taken or not ignored");

  a_enc_preset: assert property (enc_edge |=> enc_pos_o == $past(preset_val))
    else $error("encoder counter not loaded by preset");

  a_move_done: assert property (profile_done_i |=> move_cmp_o
                                ##1 (move_cmp_o || $past(cmp_clear)))
    else $error("move complete not set or dropped without cause");

  a_status_read: assert property (bus_rd_i && (bus_addr_i == ADDR_STATUS0)
                                  |=> bus_rdata_o == $past(status0))
    else $error("status word read back wrong");

endmodule

/* sim/amch_host.sv */
// host controller model: bus master that writes command blocks and paces the segment handshake
module amch_host import amch_pkg::*; (
  input  wire logic              core_clk_i,
  input  wire logic [DATA_W-1:0] bus_rdata_i,
  output logic      [ADDR_W-1:0] bus_addr_o,
  output logic      [DATA_W-1:0] bus_wdata_o,
  output logic                   bus_wr_o,
  output logic                   bus_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    bus_addr_o  = '0;
    bus_wdata_o = '0;
    bus_wr_o    = 1'b0;
    bus_rd_o    = 1'b0;
  end

  // one-cycle write; address and data are scrambled after release so stale values never match
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    bus_addr_o  <= a;
    bus_wdata_o <= d;
    bus_wr_o    <= 1'b1;
    @(posedge core_clk_i);
    bus_wr_o    <= 1'b0;
    bus_addr_o  <= ~a;
    bus_wdata_o <= ~d;
  endtask

  // one-cycle read; data is taken in the cycle after the strobe only
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    bus_addr_o <= a;
    bus_rd_o   <= 1'b1;
    @(posedge core_clk_i);
    bus_rd_o   <= 1'b0;
    bus_addr_o <= ~a;
    #1;
    d = bus_rdata_i;
  endtask

  // poll status until the segment-wait bit reaches want; bounded so a dead handshake shows up
  task automatic wait_seg(input logic want, output int n);
    logic [DATA_W-1:0] s;
    logic              ok;
    n = 0;
    do begin
      rd(ADDR_STATUS0, s);
      n++;
      ok = want ? (s[ST_SEG_WAIT] === 1'b1 && s[ST_IN_ASSY] === 1'b1) : (s[ST_SEG_WAIT] === 1'b0);
    end while (!ok && n < 20);
  endtask

  // send one segment block and finish its handshake; returns the poll counts of both phases
  task automatic seg(input logic [DATA_W-1:0] w [CMD_WORDS], output int n_clr, output int n_set);
    int n0;
    wait_seg(1'b1, n0);
    for (int i = 1; i < CMD_WORDS; i++) begin
      wr(ADDR_W'(i), (i == 8) ? 16'h0000 : w[i]);
    end
    wr(5'h00, 16'h1800);
    wait_seg(1'b0, n_clr);
    wr(5'h00, 16'h0000);
    wait_seg(1'b1, n_set);
  endtask
endmodule

/* sim/test_amch_top.sv */
// self-checking bench of the command handshake with a behavioural host and profile model
module test_amch_top import amch_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk, nrst, wr, rd, done, inc, dec;
  logic                 start, dwell, rev, loading, seg_wait, mcmp, cerr;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata, rdata, dms, s;
  logic [SEG_IDX_W-1:0] ridx;
  logic [SEG_CNT_W-1:0] scnt;
  logic [POS_W-1:0]     pos;
  logic [SPD_W-1:0]     spd;
  logic [RATE_W-1:0]    acc, dcl, jrk;
  logic [ENC_W-1:0]     enc, e_enc;
  logic [31:0]          r, v;
  logic [DATA_W-1:0]    w [CMD_WORDS];
  logic [SEG_W-1:0]     q [$];
  int                   n_fail, comparisons, seed, na, nb;

  // clock and time-zero input values
  initial clk = 1'b0;
  always #50 clk = ~clk;
  initial begin
    nrst = 1'b0;
    done = 1'b0;
    inc  = 1'b0;
    dec  = 1'b0;
    ridx = '0;
  end

  amch_host host_inst (.core_clk_i(clk), .bus_rdata_i(rdata), .bus_addr_o(addr),
    .bus_wdata_o(wdata), .bus_wr_o(wr), .bus_rd_o(rd));

  amch_top amch_top_inst (.core_clk_i(clk), .nrst_i(nrst), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata),
    .profile_done_i(done), .enc_inc_i(inc), .enc_dec_i(dec), .seg_rd_idx_i(ridx),
    .run_start_o(start), .run_dwell_o(dwell), .run_reverse_o(rev), .run_dwell_ms_o(dms),
    .run_seg_count_o(scnt), .seg_pos_o(pos), .seg_speed_o(spd), .seg_accel_o(acc),
    .seg_decel_o(dcl), .seg_jerk_o(jrk), .loading_o(loading), .seg_wait_o(seg_wait),
    .move_cmp_o(mcmp), .cmd_err_o(cerr), .enc_pos_o(enc));

  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // motion engine reports a finished profile, then the completion flag is looked at
  task automatic pulse_done();
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
    chk("move_cmp_set", 1, mcmp);
  endtask

  // write a command code and step to the edge where its action has landed
  task automatic cmd(input logic [DATA_W-1:0] c);
    host_inst.wr(5'h00, c);
    @(posedge clk);
    #1;
  endtask

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #(20000 * 100);
    n_fail++;
    complete_run();
  end

  // main sequence
  initial begin
    seed = 69924;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    host_inst.rd(ADDR_STATUS0, s);
    chk("status_reset", 16'h0000, s);
    host_inst.rd(5'h1F, s);
    chk("unmapped", 16'h0000, s);
    // encoder preset from a random signed 24-bit value, then single steps
    pulse_done();
    r = $random(seed);
    e_enc = {{8{r[23]}}, r[23:0]};
    host_inst.wr(ADDR_W'(W_POS_UP), e_enc[31:16]);
    host_inst.wr(ADDR_W'(W_POS_LO), e_enc[15:0]);
    cmd(CODE_ENC_PRESET);
    chk("enc_preset", e_enc, enc);
    chk("move_cmp_preset", 0, mcmp);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      inc <= (k != 2);
      dec <= (k != 0);
      @(posedge clk);
      inc <= 1'b0;
      dec <= 1'b0;
      #1;
      e_enc = e_enc + 32'(1 - k);
      chk("enc_step", e_enc, enc);
    end
    host_inst.rd(ADDR_ENC_LO, s);
    chk("enc_lo", e_enc[15:0], s);
    // first block with garbage left in every other word
    host_inst.wr(5'h00, 16'h0000);
    for (int i = 1; i < CMD_WORDS; i++) host_inst.wr(ADDR_W'(i), 16'($random(seed)));
    cmd(CODE_FIRST);
    chk("load_flags", 2'b11, {loading, seg_wait});
    host_inst.rd(ADDR_STATUS0, s);
    chk("status_load", 16'h0300, s);
    // seventeen segments: the last must be refused and flagged
    for (int i = 0; i <= MAX_SEGS; i++) begin
      r = $random(seed);
      v = ($random(seed) & 32'h1FFFFF) | 32'h1;
      w[1] = 16'($random(seed));
      w[2] = {{8{r[23]}}, r[23:16]};
      w[3] = r[15:0];
      w[4] = v[31:16];
      w[5] = v[15:0];
      w[6] = 16'(($random(seed) & 32'hFFF) + 1);
      w[7] = 16'(($random(seed) & 32'hFFF) + 1);
      w[8] = 16'h0000;
      w[9] = 16'($random(seed) & 32'hFFF);
      if (q.size() < MAX_SEGS) q.push_back({r[23:0], v[21:0], w[6][12:0], w[7][12:0], w[9][12:0]});
      host_inst.seg(w, na, nb);
      chk("seg_ack_polls", 1, na);
      chk("seg_rearm_polls", 1, nb);
      chk("cmd_err", 96'(i == MAX_SEGS), cerr);
    end
    host_inst.rd(ADDR_SEG_CNT, s);
    chk("seg_count", 16'(MAX_SEGS), s);
    for (int i = 0; i < MAX_SEGS; i++) begin
      @(posedge clk);
      ridx <= SEG_IDX_W'(i);
      repeat (2) @(posedge clk);
      #1;
      chk("segment", q[i], {pos, spd, acc, dcl, jrk});
    end
    // run the same profile blended, then with dwell
    for (int m = 0; m < 2; m++) begin
      pulse_done();
      v = $random(seed);
      host_inst.wr(5'h00, 16'h0000);
      host_inst.wr(ADDR_W'(W_OPT), (m != 0) ? 16'h0210 : 16'h0010);
      host_inst.wr(ADDR_W'(W_AUX), v[15:0]);
      cmd(CODE_RUN);
      chk("run_start", 1, start);
      chk("run_mode", {m[0], ~m[0]}, {dwell, rev});
      chk("run_dwell_ms", (m != 0) ? v[15:0] : 16'h0000, dms);
      chk("run_count", 16, scnt);
      chk("run_flags", 3'b000, {loading, seg_wait, mcmp});
      @(posedge clk);
      #1;
      chk("run_pulse_end", 0, start);
    end
    // error reset clears both flags
    pulse_done();
    cmd(CODE_RESET_ERR);
    chk("err_reset", 2'b00, {mcmp, cerr});
    // a repeated first block restarts the load; position preset only clears move complete
    cmd(CODE_FIRST);
    host_inst.rd(ADDR_SEG_CNT, s);
    chk("seg_count_restart", 16'h0000, s);
    chk("load_restart", 2'b11, {loading, seg_wait});
    pulse_done();
    cmd(CODE_POS_PRESET);
    chk("move_cmp_pos_preset", 2'b01, {mcmp, loading});
    // reset in mid-load drops the load, the flags and the encoder counter
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("reset_flags", 4'b0000, {loading, seg_wait, mcmp, cerr});
    host_inst.rd(ADDR_STATUS0, s);
    chk("status_mid_reset", 16'h0000, s);
    host_inst.rd(ADDR_ENC_UP, s);
    chk("enc_reset", 16'h0000, s);
    complete_run();
  end
endmodule
